//--- verilog/rcc_pkg.sv
// Purpose: constants for the reset and clock controller
// Assumes: pclk is the system clock and runs at 50 MHz
// Notes: times are held in ns and turned into cycle counts here
package rcc_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 20;

	// reset delay phase, a least time so counts round up
	localparam int RST_DELAY_NS = 20000;
	localparam int RST_DELAY_CYC =
		(RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 10;
	localparam logic [RST_CNT_W-1:0] RST_LOAD =
		RST_CNT_W'(RST_DELAY_CYC - 1);

	// oscillator startup times
	localparam int FINT_START_NS = 2000;
	localparam int FEXT_START_NS = 4000;
	localparam int PLL_LOCK_NS = 2000;
	localparam int SEXT_START_NS = 60000;
	localparam int SINT_START_NS = 1000;
	localparam int OSC_CNT_W = 12;
	localparam int NUM_OSC = 5;
	localparam logic [NUM_OSC-1:0][OSC_CNT_W-1:0] OSC_START_CYC = {
		OSC_CNT_W'((SINT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
		OSC_CNT_W'((SEXT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
		OSC_CNT_W'((PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
		OSC_CNT_W'((FEXT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
		OSC_CNT_W'((FINT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)};

	// oscillator indices
	localparam int OSC_FINT = 0;
	localparam int OSC_FEXT = 1;
	localparam int OSC_PLL = 2;
	localparam int OSC_SEXT = 3;
	localparam int OSC_SINT = 4;

	// system clock sources
	typedef enum logic [1:0] {
		RCC_SRC_FINT = 2'b00,
		RCC_SRC_FEXT = 2'b01,
		RCC_SRC_PLL = 2'b10
	} rcc_src_t;

	// register byte offsets
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_CLK_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_CLK_CFG = 12'h004;
	localparam logic [ADDR_W-1:0] REG_BKP_CTRL = 12'h008;
	localparam logic [ADDR_W-1:0] REG_RST_STAT = 12'h00C;

	// clock_ctrl_reg fields
	localparam int CR_FINT_EN = 0;
	localparam int CR_FINT_RDY = 1;
	localparam int CR_TRIM_LSB = 3;
	localparam int CR_CAL_LSB = 8;
	localparam int CR_FEXT_EN = 16;
	localparam int CR_FEXT_RDY = 17;
	localparam int CR_FEXT_BYP = 18;
	localparam int CR_PLL_EN = 24;
	localparam int CR_PLL_RDY = 25;

	// clock configuration fields
	localparam int CF_SW_LSB = 0;
	localparam int CF_SWS_LSB = 2;
	localparam int CF_AHB_LSB = 4;
	localparam int CF_APBL_LSB = 8;
	localparam int CF_APBH_LSB = 11;
	localparam int CF_ADC_LSB = 14;
	localparam int CF_PLL_SRC = 16;
	localparam int CF_MUL_LSB = 18;
	localparam int CF_USB_PRE = 22;

	// backup_domain_ctrl_reg fields
	localparam int BD_SEXT_EN = 0;
	localparam int BD_SEXT_RDY = 1;
	localparam int BD_SOFT_RST = 16;

	// reset_clock_status_reg fields
	localparam int RS_SINT_EN = 0;
	localparam int RS_SINT_RDY = 1;
	localparam int RS_CLR_FLAGS = 24;
	localparam int RS_FLAG_LSB = 26;
	localparam int NUM_FLAGS = 6;
	localparam int FL_PIN = 0;
	localparam int FL_SOFT = 1;
	localparam int FL_INDEPENDENT_WATCHDOG = 2;
	localparam int FL_WINDOW_WATCHDOG = 3;
	localparam int FL_LOWPWR = 4;
	localparam int FL_POWER = 5;

	// trim reset value and last counts of the tick and usb counters
	localparam logic [4:0] TRIM_RST = 5'h10;
	localparam logic [3:0] TICK_LAST = 4'h7;
	localparam logic [1:0] USB_LAST = 2'h2;
endpackage

//--- verilog/rcc_top.sv
// Purpose: reset merge, oscillator gating and clock enables
// Assumes: presetn is the deepest reset (backup domain power on);
// Assumes: all inputs synchronous to pclk, pclk is the system clock
// Notes: divided clocks leave as one-cycle enables of pclk
`timescale 1ns/100ps
`default_nettype none
module rcc_top
	import rcc_pkg::*;
#(
	parameter logic [7:0] FAST_INT_CAL = 8'h80 // arbitrary factory value
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources
	input wire logic external_reset_pin_n_i,
	input wire logic window_watchdog_reset,
	input wire logic independent_watchdog_reset,
	input wire logic core_reset_request,
	input wire logic power_down_reset,
	input wire logic standby_exit,
	// low-power entry
	input wire logic standby_entry_done,
	input wire logic stop_entry_done,
	input wire logic standby_reset_option_n,
	input wire logic stop_reset_option_n,
	output logic standby_enter,
	output logic stop_enter,
	// reset pin and reset outputs
	output logic external_reset_pin_n_o,
	output logic external_reset_pin_n_oe,
	output logic system_reset_n,
	output logic power_reset_n,
	output logic backup_domain_reset_n,
	// oscillator control
	output logic [NUM_OSC-1:0] osc_enable,
	output logic [NUM_OSC-1:0] osc_release,
	output logic fast_ext_bypass,
	output logic [4:0] fast_int_trim,
	output logic [7:0] fast_int_calibration,
	output logic pll_source_ext,
	output logic [3:0] pll_multiplier,
	output logic [1:0] system_clock_sel,
	// clock enables
	output logic ahb_en,
	output logic apb_low_en,
	output logic apb_high_en,
	output logic tim_low_en,
	output logic tim_high_en,
	output logic core_tick_en,
	output logic adc_en,
	output logic usb_en
);
	typedef struct packed {
		logic rst_act;
		logic pwr_act;
		logic [RST_CNT_W-1:0] rst_cnt;
		logic pin_oe;
		logic sys_rst_n;
		logic pwr_rst_n;
		logic bkp_rst_n;
		logic [NUM_FLAGS-1:0] flags;
		logic [NUM_OSC-1:0] osc_en;
		logic [NUM_OSC-1:0] osc_rdy;
		logic [NUM_OSC-1:0][OSC_CNT_W-1:0] osc_cnt;
		logic [4:0] trim;
		logic [7:0] cal;
		logic bypass;
		rcc_src_t sw;
		rcc_src_t sws;
		logic [3:0] ahb_pre;
		logic [1:0][2:0] apb_pre; // 0 low-speed, 1 high-speed
		logic [1:0] adc_pre;
		logic pll_src;
		logic [3:0] pll_mul;
		logic usb_pre;
		logic bdsoft;
		logic [8:0] ahb_cnt;
		logic [1:0][3:0] apb_cnt;
		logic [2:0] tick_cnt;
		logic [2:0] adc_cnt;
		logic [1:0] usb_cnt;
		logic ahb_en;
		logic [1:0] apb_en;
		logic [1:0] tim_en;
		logic tick_en;
		logic adc_en;
		logic usb_en;
		logic standby_go;
		logic stop_go;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rcc_state_t;

	// power-on values of every field
	function automatic rcc_state_t rcc_reset_state();
		rcc_state_t s;
		s = '0;
		s.rst_act = 1'b1;
		s.pwr_act = 1'b1;
		s.rst_cnt = RST_LOAD;
		s.pin_oe = 1'b1;
		s.osc_en[OSC_FINT] = 1'b1;
		s.trim = TRIM_RST;
		s.cal = FAST_INT_CAL;
		s.sw = RCC_SRC_FINT;
		s.sws = RCC_SRC_FINT;
		return s;
	endfunction

	localparam rcc_state_t RST_STATE = rcc_reset_state();

	// ahb prescaler code to divide ratio: 0xxx is 1, else 2..256
	function automatic logic [9:0] ahb_div(input logic [3:0] p);
		return p[3] ? (10'h001 << ({1'b0, p[2:0]} + 4'h1)) : 10'h001;
	endfunction

	// apb prescaler code to divide ratio: 0xx is 1, else 2..16
	function automatic logic [4:0] apb_div(input logic [2:0] p);
		return p[2] ? (5'h01 << ({1'b0, p[1:0]} + 3'h1)) : 5'h01;
	endfunction

	rcc_state_t q;
	rcc_state_t d;
	logic pin_ev;
	logic sb_hit;
	logic st_hit;
	logic sys_ev;
	logic pwr_ev;
	logic start_ev;

	// reset sources; the pin only counts while we are not pulling it,
	// otherwise our own drive would retrigger the delay forever
	assign pin_ev = !external_reset_pin_n_i && !q.pin_oe;
	assign sb_hit = standby_entry_done && !standby_reset_option_n;
	assign st_hit = stop_entry_done && !stop_reset_option_n;
	assign sys_ev = pin_ev || window_watchdog_reset
		|| independent_watchdog_reset || core_reset_request
		|| sb_hit || st_hit;
	assign pwr_ev = power_down_reset || standby_exit;
	assign start_ev = sys_ev || pwr_ev;

	// next-state logic
	always_comb begin
		rcc_state_t keep;
		logic [31:0] rd;
		logic wr;
		logic mapped;
		logic tgt_rdy;
		logic pll_in_rdy;
		logic [9:0] ahb_m;
		logic [4:0] apb_m;
		keep = '0;
		rd = '0;
		wr = 1'b0;
		mapped = 1'b0;
		tgt_rdy = 1'b0;
		pll_in_rdy = 1'b0;
		ahb_m = '0;
		apb_m = '0;
		d = q;
		d.ahb_en = 1'b0;
		d.apb_en = '0;
		d.tim_en = '0;
		d.tick_en = 1'b0;
		d.adc_en = 1'b0;
		d.usb_en = 1'b0;

		// low-power entry goes ahead only when its reset option is off (option input high)
		d.standby_go = standby_entry_done && standby_reset_option_n;
		d.stop_go = stop_entry_done && stop_reset_option_n;

		// register read is prepared in setup so data stands in access
		unique case (paddr)
			REG_CLK_CTRL: begin
				mapped = 1'b1;
				rd[CR_FINT_EN] = q.osc_en[OSC_FINT];
				rd[CR_FINT_RDY] = q.osc_rdy[OSC_FINT];
				rd[CR_TRIM_LSB +: 5] = q.trim;
				rd[CR_CAL_LSB +: 8] = q.cal;
				rd[CR_FEXT_EN] = q.osc_en[OSC_FEXT];
				rd[CR_FEXT_RDY] = q.osc_rdy[OSC_FEXT];
				rd[CR_FEXT_BYP] = q.bypass;
				rd[CR_PLL_EN] = q.osc_en[OSC_PLL];
				rd[CR_PLL_RDY] = q.osc_rdy[OSC_PLL];
			end
			REG_CLK_CFG: begin
				mapped = 1'b1;
				rd[CF_SW_LSB +: 2] = q.sw;
				rd[CF_SWS_LSB +: 2] = q.sws;
				rd[CF_AHB_LSB +: 4] = q.ahb_pre;
				rd[CF_APBL_LSB +: 3] = q.apb_pre[0];
				rd[CF_APBH_LSB +: 3] = q.apb_pre[1];
				rd[CF_ADC_LSB +: 2] = q.adc_pre;
				rd[CF_PLL_SRC] = q.pll_src;
				rd[CF_MUL_LSB +: 4] = q.pll_mul;
				rd[CF_USB_PRE] = q.usb_pre;
			end
			REG_BKP_CTRL: begin
				mapped = 1'b1;
				rd[BD_SEXT_EN] = q.osc_en[OSC_SEXT];
				rd[BD_SEXT_RDY] = q.osc_rdy[OSC_SEXT];
				rd[BD_SOFT_RST] = q.bdsoft;
			end
			REG_RST_STAT: begin
				mapped = 1'b1;
				rd[RS_SINT_EN] = q.osc_en[OSC_SINT];
				rd[RS_SINT_RDY] = q.osc_rdy[OSC_SINT];
				rd[RS_FLAG_LSB +: NUM_FLAGS] = q.flags;
			end
			default: mapped = 1'b0;
		endcase
		d.pready = psel && !penable;
		d.pslverr = psel && !penable && !mapped;
		d.prdata = (psel && !penable) ? rd : '0;

		// register writes take effect at the access edge
		wr = psel && penable && pwrite && q.pready && !q.pslverr;
		if (wr) begin
			unique case (paddr)
				REG_CLK_CTRL: begin
					d.osc_en[OSC_FINT] = pwdata[CR_FINT_EN];
					d.trim = pwdata[CR_TRIM_LSB +: 5];
					d.osc_en[OSC_FEXT] = pwdata[CR_FEXT_EN];
					// bypass only changes with the oscillator off
					if (!q.osc_en[OSC_FEXT])
						d.bypass = pwdata[CR_FEXT_BYP];
					d.osc_en[OSC_PLL] = pwdata[CR_PLL_EN];
				end
				REG_CLK_CFG: begin
					// code 3 names no source and is dropped
					if (pwdata[CF_SW_LSB +: 2] != 2'b11)
						d.sw = rcc_src_t'(pwdata[CF_SW_LSB +: 2]);
					d.ahb_pre = pwdata[CF_AHB_LSB +: 4];
					d.apb_pre[0] = pwdata[CF_APBL_LSB +: 3];
					d.apb_pre[1] = pwdata[CF_APBH_LSB +: 3];
					d.adc_pre = pwdata[CF_ADC_LSB +: 2];
					d.usb_pre = pwdata[CF_USB_PRE];
					if (!q.osc_en[OSC_PLL]) begin
						d.pll_src = pwdata[CF_PLL_SRC];
						d.pll_mul = pwdata[CF_MUL_LSB +: 4];
					end
				end
				REG_BKP_CTRL: begin
					d.osc_en[OSC_SEXT] = pwdata[BD_SEXT_EN];
					d.bdsoft = pwdata[BD_SOFT_RST];
				end
				REG_RST_STAT: begin
					d.osc_en[OSC_SINT] = pwdata[RS_SINT_EN];
					if (pwdata[RS_CLR_FLAGS])
						d.flags = '0;
				end
				default: d.flags = d.flags;
			endcase
		end

		// a source feeding the system clock cannot be stopped
		unique case (q.sws)
			RCC_SRC_FINT: d.osc_en[OSC_FINT] = 1'b1;
			RCC_SRC_FEXT: d.osc_en[OSC_FEXT] = 1'b1;
			RCC_SRC_PLL: begin
				d.osc_en[OSC_PLL] = 1'b1;
				if (q.pll_src)
					d.osc_en[OSC_FEXT] = 1'b1;
				else
					d.osc_en[OSC_FINT] = 1'b1;
			end
			default: d.osc_en = d.osc_en;
		endcase

		// backup soft reset holds the slow external oscillator off
		if (q.bdsoft)
			d.osc_en[OSC_SEXT] = 1'b0;

		// startup timers; the PLL input is the halved internal
		// oscillator or the external one and must be ready first
		pll_in_rdy = q.pll_src ? q.osc_rdy[OSC_FEXT] : q.osc_rdy[OSC_FINT];
		// the next enable is used so ready drops at the same edge as it
		for (int i = 0; i < NUM_OSC; i++) begin
			if (!d.osc_en[i] || (i == OSC_PLL && !pll_in_rdy)) begin
				d.osc_cnt[i] = '0;
				d.osc_rdy[i] = 1'b0;
			end else if (!q.osc_rdy[i]) begin
				if (q.osc_cnt[i] == OSC_START_CYC[i] - 12'h001)
					d.osc_rdy[i] = 1'b1;
				else
					d.osc_cnt[i] = q.osc_cnt[i] + 12'h001;
			end
		end

		// switch only once the requested source reports ready
		unique case (q.sw)
			RCC_SRC_FINT: tgt_rdy = q.osc_rdy[OSC_FINT];
			RCC_SRC_FEXT: tgt_rdy = q.osc_rdy[OSC_FEXT];
			RCC_SRC_PLL: tgt_rdy = q.osc_rdy[OSC_PLL];
			default: tgt_rdy = 1'b0;
		endcase
		if (tgt_rdy)
			d.sws = q.sw;

		// ahb divider counts system clock cycles
		ahb_m = ahb_div(q.ahb_pre);
		if ({1'b0, q.ahb_cnt} >= ahb_m - 10'h001) begin
			d.ahb_cnt = '0;
			d.ahb_en = 1'b1;
		end else begin
			d.ahb_cnt = q.ahb_cnt + 9'h001;
		end

		// apb dividers count ahb pulses; timers tick at the half point
		// too, giving twice the apb rate when the prescaler is above one
		for (int i = 0; i < 2; i++) begin
			apb_m = apb_div(q.apb_pre[i]);
			if (q.ahb_en) begin
				if ({1'b0, q.apb_cnt[i]} >= apb_m - 5'h01) begin
					d.apb_cnt[i] = '0;
					d.apb_en[i] = 1'b1;
					d.tim_en[i] = 1'b1;
				end else begin
					d.apb_cnt[i] = q.apb_cnt[i] + 4'h1;
					if ({1'b0, q.apb_cnt[i]} == (apb_m >> 1) - 5'h01)
						d.tim_en[i] = 1'b1;
				end
			end
		end

		// core tick enable: every eighth ahb pulse
		if (q.ahb_en) begin
			d.tick_cnt = q.tick_cnt + 3'h1;
			d.tick_en = ({1'b0, q.tick_cnt} == TICK_LAST);
		end

		// converter enable: high apb over 2, 4, 6 or 8
		if (q.apb_en[1]) begin
			if (q.adc_cnt >= {q.adc_pre, 1'b1}) begin
				d.adc_cnt = '0;
				d.adc_en = 1'b1;
			end else begin
				d.adc_cnt = q.adc_cnt + 3'h1;
			end
		end

		// usb enable from the PLL: all cycles, or two of every three
		if (q.osc_rdy[OSC_PLL]) begin
			d.usb_cnt = (q.usb_cnt == USB_LAST) ? 2'h0 : q.usb_cnt + 2'h1;
			d.usb_en = q.usb_pre || (q.usb_cnt != USB_LAST);
		end

		// flags set after the software clear so a same-cycle event wins
		if (pwr_ev)
			d.flags = '0;
		if (pin_ev)
			d.flags[FL_PIN] = 1'b1;
		if (core_reset_request)
			d.flags[FL_SOFT] = 1'b1;
		if (independent_watchdog_reset)
			d.flags[FL_INDEPENDENT_WATCHDOG] = 1'b1;
		if (window_watchdog_reset)
			d.flags[FL_WINDOW_WATCHDOG] = 1'b1;
		if (sb_hit || st_hit)
			d.flags[FL_LOWPWR] = 1'b1;
		if (pwr_ev)
			d.flags[FL_POWER] = 1'b1;

		// reset delay counter, reloaded by every new source
		if (start_ev) begin
			d.rst_cnt = RST_LOAD;
			d.rst_act = 1'b1;
			if (pwr_ev)
				d.pwr_act = 1'b1;
		end else if (q.rst_act) begin
			if (q.rst_cnt == '0) begin
				d.rst_act = 1'b0;
				d.pwr_act = 1'b0;
			end else begin
				d.rst_cnt = q.rst_cnt - 1'b1;
			end
		end

		// while the delay runs everything returns to reset values,
		// except reset flags, the backup domain and the internal fast oscillator timer
		if (d.rst_act) begin
			keep = RST_STATE;
			keep.flags = d.flags;
			keep.osc_en[OSC_SEXT] = d.osc_en[OSC_SEXT];
			keep.osc_rdy[OSC_SEXT] = d.osc_rdy[OSC_SEXT];
			keep.osc_cnt[OSC_SEXT] = d.osc_cnt[OSC_SEXT];
			// internal fast osc runs on, so it is ready when the core restarts
			keep.osc_rdy[OSC_FINT] = d.osc_rdy[OSC_FINT];
			keep.osc_cnt[OSC_FINT] = d.osc_cnt[OSC_FINT];
			keep.bdsoft = d.bdsoft;
			keep.rst_act = d.rst_act;
			keep.pwr_act = d.pwr_act;
			keep.rst_cnt = d.rst_cnt;
			d = keep;
		end

		// reset outputs follow the delay phase, the backup reset the soft bit
		d.pin_oe = d.rst_act;
		d.sys_rst_n = !d.rst_act;
		d.pwr_rst_n = !d.pwr_act;
		d.bkp_rst_n = !d.bdsoft;
	end

	// state register; presetn is the backup power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= RST_STATE;
		else
			q <= d;
	end

	// outputs straight from state
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign standby_enter = q.standby_go;
	assign stop_enter = q.stop_go;
	assign external_reset_pin_n_o = 1'b0 & q.pin_oe;
	assign external_reset_pin_n_oe = q.pin_oe;
	assign system_reset_n = q.sys_rst_n;
	assign power_reset_n = q.pwr_rst_n;
	assign backup_domain_reset_n = q.bkp_rst_n;
	assign osc_enable = q.osc_en;
	assign osc_release = q.osc_rdy;
	assign fast_ext_bypass = q.bypass && q.osc_en[OSC_FEXT];
	assign fast_int_trim = q.trim;
	assign fast_int_calibration = q.cal;
	assign pll_source_ext = q.pll_src;
	assign pll_multiplier = q.pll_mul;
	assign system_clock_sel = q.sws;
	assign ahb_en = q.ahb_en;
	assign apb_low_en = q.apb_en[0];
	assign apb_high_en = q.apb_en[1];
	assign tim_low_en = q.tim_en[0];
	assign tim_high_en = q.tim_en[1];
	assign core_tick_en = q.tick_en;
	assign adc_en = q.adc_en;
	assign usb_en = q.usb_en;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pin_held_low: assert property (q.rst_act |-> q.pin_oe
		&& !q.sys_rst_n) else $error("reset pin not low in delay");
	a_core_req_rst: assert property (core_reset_request |=>
		q.rst_act && q.flags[FL_SOFT] && q.rst_cnt == RST_LOAD)
		else $error("core request gave no reset");
	a_standby_rst: assert property (sb_hit |=>
		q.rst_act && !q.standby_go) else $error("standby not reset");
	a_stop_rst: assert property (st_hit |=>
		q.rst_act && !q.stop_go) else $error("stop not reset");
	a_delay_count: assert property (q.rst_act && q.rst_cnt != '0
		&& !start_ev |=> q.rst_act && q.rst_cnt == $past(q.rst_cnt) - 1)
		else $error("reset delay miscounted");
	a_switch_ready: assert property (!$stable(q.sws) && !q.rst_act
		|-> q.osc_rdy[q.sws]) else $error("switched to unready source");
	a_after_reset: assert property ($fell(q.rst_act)
		|-> q.sws == RCC_SRC_FINT) else $error("reset left wrong source");
	a_tick_eighth: assert property (q.tick_en |=>
		!q.tick_en [*7]) else $error("tick enable too frequent");
	a_pll_frozen: assert property ($past(q.osc_en[OSC_PLL])
		&& q.osc_en[OSC_PLL] |-> $stable(q.pll_mul) && $stable(q.pll_src))
		else $error("PLL settings changed while enabled");
	a_fext_gate: assert property (q.osc_rdy[OSC_FEXT]
		|-> q.osc_en[OSC_FEXT]) else $error("ready without enable");
	a_flags_kept: assert property (q.rst_act && !pwr_ev &&
		!(psel && penable && pwrite && paddr == REG_RST_STAT)
		|=> (q.flags & $past(q.flags)) == $past(q.flags))
		else $error("flags lost");
endmodule
`default_nettype wire

//--- tb/rcc_peer.sv
// Purpose: core and peripheral side of the controller
// Assumes: clock enables are one-cycle pulses of pclk
// Notes: counts enables per window; core holds its reset request
`timescale 1ns/100ps
`default_nettype none
module rcc_peer (
	// clock and reset seen by the core
	input wire logic pclk,
	input wire logic system_reset_n,
	// bench control
	input wire logic clr,
	input wire logic soft_go,
	// clock enables watched
	input wire logic [7:0] en,
	// core side outputs
	output var logic core_reset_request,
	output var int cnt [8]
);
	initial core_reset_request = 1'b0;

	// count each enable pulse; clr opens a new window
	always @(posedge pclk) begin
		for (int i = 0; i < 8; i++) begin
			if (clr)
				cnt[i] <= 0;
			else if (en[i])
				cnt[i] <= cnt[i] + 1;
		end
	end

	// a real core keeps asking until it is itself reset
	always @(posedge pclk) begin
		if (soft_go)
			core_reset_request <= 1'b1;
		else if (!system_reset_n)
			core_reset_request <= 1'b0;
	end
endmodule
`default_nettype wire

//--- tb/rcc_top_bench.sv
// Purpose: self-checking bench for the reset and clock controller
// Assumes: zero-wait APB slave, reset delay of about 1000 cycles
// Notes: read answers are noted in a queue and matched as they come
`timescale 1ns/100ps
`default_nettype none
module rcc_top_bench;
	import rcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, clr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, external_reset_pin_n_oe, system_reset_n;
	logic power_reset_n, backup_domain_reset_n, core_reset_request;
	logic [NUM_OSC-1:0] osc_release;
	logic [1:0] system_clock_sel, done, opt_n;
	logic [5:0] src;
	logic pin_o, byp_o, psrc_o;
	logic [4:0] trim_o;
	logic [7:0] cal_o;
	logic [3:0] mul_o;
	wire [1:0] enter;
	wire [7:0] en;
	int cnt [8];
	int fl [6] = '{FL_PIN, FL_WINDOW_WATCHDOG, FL_INDEPENDENT_WATCHDOG, FL_SOFT, FL_POWER, FL_POWER};
	int err_count, check_count;
	logic [15:0] lf;
	logic [32:0] eq [$];
	logic [32:0] mq [$];

	rcc_top #(.FAST_INT_CAL(8'h5A)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr,
		.external_reset_pin_n_i(~src[0]), .window_watchdog_reset(src[1]),
		.independent_watchdog_reset(src[2]), .core_reset_request,
		.power_down_reset(src[4]), .standby_exit(src[5]),
		.standby_entry_done(done[0]), .stop_entry_done(done[1]),
		.standby_reset_option_n(opt_n[0]), .stop_reset_option_n(opt_n[1]),
		.standby_enter(enter[0]), .stop_enter(enter[1]),
		.external_reset_pin_n_o(pin_o), .external_reset_pin_n_oe,
		.system_reset_n, .power_reset_n, .backup_domain_reset_n,
		.osc_enable(), .osc_release, .fast_ext_bypass(byp_o),
		.fast_int_trim(trim_o), .fast_int_calibration(cal_o),
		.pll_source_ext(psrc_o), .pll_multiplier(mul_o),
		.system_clock_sel, .ahb_en(en[0]), .apb_low_en(en[1]),
		.apb_high_en(en[2]), .tim_low_en(en[3]), .tim_high_en(en[4]),
		.core_tick_en(en[5]), .adc_en(en[6]), .usb_en(en[7]));
	rcc_peer peer (.pclk, .system_reset_n, .clr, .soft_go(src[3]), .en,
		.core_reset_request, .cnt);

	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// pulse counts drift by a few at window edges
	function automatic logic near(input int a, input int b);
		return (a - b <= 16) && (b - a <= 16);
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] ex);
		check_count++;
		if (got !== ex) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, got, ex);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// starts on the next edge so back-to-back calls never collide
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		eq.push_back(33'h0);
		mq.push_back(33'h1_0000_0000);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e,
		input logic [32:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	// the pin must stay driven for the whole delay
	task automatic wait_rel();
		int n;
		n = 0;
		while (system_reset_n !== 1'b1 && n < 1200) begin
			@(posedge pclk);
			n++;
			if (system_reset_n !== 1'b1) begin
				chk(external_reset_pin_n_oe, 1'b1);
				chk(pin_o, 1'b0);
			end
		end
		chk(n > 990 && n < 1010, 1'b1);
		if (n >= 1200)
			final_report();
	endtask
	task automatic wait_sel(input logic [1:0] v);
		int n;
		n = 0;
		while (system_clock_sel !== v && n < 600) begin
			@(posedge pclk);
			n++;
		end
		chk(system_clock_sel, v);
		if (n >= 600)
			final_report();
	endtask
	task automatic trig(input int i);
		@(posedge pclk);
		src <= 6'h01 << i;
		@(posedge pclk);
		src <= 6'h00;
		repeat (2) @(posedge pclk);
		chk(system_reset_n, 1'b0);
		chk(power_reset_n, i < 4);
	endtask
	task automatic pulse(input int j);
		@(posedge pclk);
		done[j] <= 1'b1;
		@(posedge pclk);
		done[j] <= 1'b0;
		@(posedge pclk);
	endtask

	// answer watcher: each completed access takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && mq.size() > 0) begin
			chk({pslverr, prdata} & mq[0], eq[0]);
			eq.pop_front();
			mq.pop_front();
		end
	end

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		logic [4:0] tr;
		logic [3:0] m;
		err_count = 0;
		check_count = 0;
		lf = 16'h005B;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		src = '0;
		done = '0;
		opt_n = 2'b11;
		clr = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(power_reset_n, 1'b0);
		wait_rel();
		chk(system_clock_sel, RCC_SRC_FINT);
		chk(osc_release[OSC_FINT], 1'b1);
		rd(REG_CLK_CTRL, {17'h0, 8'h5A, TRIM_RST, 3'h1}, 33'h1_0000_FFF9);
		rd(12'h010, 33'h1_0000_0000, 33'h1_0000_0000);
		lf = nx(lf);
		tr = lf[4:0];
		wr(REG_CLK_CTRL, {16'h0, 8'hA5, tr, 3'h1});
		rd(REG_CLK_CTRL, {17'h0, 8'h5A, tr, 3'h0}, 33'h1_0000_FFF8);
		chk(trim_o, tr);
		chk(cal_o, 8'h5A);
		$display("test reset and trim done");
		for (int k = 0; k < 4; k++) begin
			// prescalers kept within bus limits at this rate
			wr(REG_CLK_CFG, {16'h0, k[1:0], 3'h0, 3'h4, 8'h0});
			@(posedge pclk);
			clr <= 1'b1;
			@(posedge pclk);
			clr <= 1'b0;
			repeat (480) @(posedge pclk);
			chk(near(cnt[5] * 8, cnt[0]), 1'b1);
			chk(near(cnt[3], cnt[1] * 2), 1'b1);
			chk(near(cnt[4], cnt[2]), 1'b1);
			chk(near(cnt[6] * (2 * k + 2), cnt[2]), 1'b1);
		end
		$display("test prescalers done");
		// bypass is written together with the enable, while still off
		wr(REG_CLK_CTRL, 32'h0005_0081);
		wr(REG_CLK_CFG, 32'h0000_0001);
		chk(system_clock_sel, RCC_SRC_FINT);
		wait_sel(RCC_SRC_FEXT);
		chk(osc_release[OSC_FEXT], 1'b1);
		chk(byp_o, 1'b1);
		lf = nx(lf);
		m = lf[3:0];
		wr(REG_CLK_CFG, {10'h0, m, 1'b0, 1'b1, 16'h0001});
		wr(REG_CLK_CTRL, 32'h0101_0081);
		wr(REG_CLK_CFG, {10'h0, ~m, 1'b0, 1'b0, 16'h0002});
		rd(REG_CLK_CFG, {11'h0, m, 2'h1, 16'h0}, 33'h1_003F_0000);
		chk(mul_o, m);
		chk(psrc_o, 1'b1);
		wait_sel(RCC_SRC_PLL);
		chk(osc_release[OSC_PLL], 1'b1);
		// usb prescaler left at zero: two enables in every three cycles
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (300) @(posedge pclk);
		chk(near(cnt[7] * 3, 600), 1'b1);
		$display("test clock switch done");
		for (int i = 0; i < 6; i++) begin
			wr(REG_CLK_CTRL, {24'h0, tr, 3'h1});
			wr(REG_RST_STAT, 32'h0100_0000);
			trig(i);
			wait_rel();
			chk(system_clock_sel, RCC_SRC_FINT);
			rd(REG_CLK_CTRL, {25'h0, TRIM_RST, 3'h0}, 33'h1_0000_00F8);
			rd(REG_RST_STAT, {1'b0, 6'h01 << fl[i], 26'h0}, 33'h1_FC00_0000);
		end
		$display("test reset sources done");
		for (int j = 0; j < 2; j++) begin
			wr(REG_RST_STAT, 32'h0100_0000);
			pulse(j);
			chk(enter[j], 1'b1);
			chk(system_reset_n, 1'b1);
			opt_n[j] <= 1'b0;
			pulse(j);
			chk(enter[j], 1'b0);
			chk(system_reset_n, 1'b0);
			opt_n[j] <= 1'b1;
			wait_rel();
			rd(REG_RST_STAT, {1'b0, 6'h01 << FL_LOWPWR, 26'h0}, 33'h1_FC00_0000);
		end
		$display("test low-power entry done");
		wr(REG_BKP_CTRL, 32'h0001_0000);
		repeat (2) @(posedge pclk);
		chk(backup_domain_reset_n, 1'b0);
		chk(system_reset_n, 1'b1);
		wr(REG_BKP_CTRL, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk(backup_domain_reset_n, 1'b1);
		$display("test backup reset done");
		final_report();
	end
endmodule
`default_nettype wire
